// *** frtcc_timer.sv ***
`timescale 1ns/1ps
// Behaviour
// - 16-bit up counter read as two bytes.
// - Alternate view; its low read keeps overflow.
// - Low byte write reloads counter to FFFCh.
// - Reset starts counter at FFFCh always.
// - Count at CPU/2, /4, /8 or external.
// - High read latches low byte until low read.
// - Without pending high read, low is live.
// - Wrap FFFFh to 0000h sets overflow flag.
// - Overflow interrupt needs enable and clear mask.
// - Status read then primary low access clears.
// - Halt stops counting; wait runs normally.
// - Select 11 uses external pin, chosen edge.
// - Counter updates synchronised to CPU clock.
// - Capture latches counter on selected pin edge.
// - Capture sets flag; shared enable requests interrupt.
// - Status read then capture low access clears.
// - Capture high read blocks captures until low.
// - Pulse or PWM mode leaves only capture two.
// - Any qualifying capture pin edge captures.
// - Compare match sets flag, pin, interrupt.
// - Compare registers software only, reset 8000h.
// - High write suspends matching until low write.
// - Status read then compare low access clears.
module frtcc_timer (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 cpu_irq_mask,
	input  wire logic                 halt_req,
	input  wire logic [1:0]           capture_pin,
	input  wire logic                 external_clock_pin,
	output logic [1:0]                compare_output_pin,
	output logic                      timer_irq
);
	import frtcc_pkg::*;

	// Bus handshake state.
	logic              aw_full_r;
	logic              w_full_r;
	logic [7:0]        aw_addr_r;
	logic [7:0]        w_data_r;
	logic              w_lane_r;
	logic [31:0]       rdata_r;
	// Timer state.
	logic [15:0]       cnt_r;
	logic [2:0]        pre_r;
	logic [7:0]        lo_latch_r;
	logic              lo_pend_r;
	logic [4:0]        flags_r;
	logic [4:0]        arm_r;
	frtcc_ctrl1_s      ctrl1_r;
	frtcc_ctrl2_s      ctrl2_r;
	logic              ext_s1_r;
	logic              ext_s2_r;
	logic              ext_s3_r;
	logic [1:0]        cap_s1_r;
	logic [1:0]        cap_s2_r;
	logic [1:0]        cap_s3_r;
	logic [15:0]       cap_val_r [2];
	logic [1:0]        cap_block_r;
	logic [15:0]       cmp_val_r [2];
	logic [1:0]        cmp_hold_r;

	// Write channel: address and data are taken in either order.
	wire        aw_take   = s_axi_awvalid & s_axi_awready;
	wire        w_take    = s_axi_wvalid & s_axi_wready;
	wire        do_write  = aw_full_r & w_full_r & ~s_axi_bvalid;
	wire        aw_full_n = (aw_full_r | aw_take) & ~do_write;
	wire        w_full_n  = (w_full_r | w_take) & ~do_write;
	wire        bvalid_n  = do_write | (s_axi_bvalid & ~s_axi_bready);
	wire        ar_take   = s_axi_arvalid & s_axi_arready;
	wire        rvalid_n  = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire [7:0]  ra        = s_axi_araddr;
	wire [7:0]  wa        = aw_addr_r;
	wire        rd_map    = (ra[1:0] == 2'h0) && (ra <= OFF_CTRL2);
	wire        wr_map    = (wa[1:0] == 2'h0) && (wa <= OFF_CTRL2);
	wire        wr_go     = do_write & wr_map & w_lane_r;

	// Read side effects are decoded at the edge that takes the read address; write side effects at the edge that raises bvalid.
	wire rd_cnt_hi  = ar_take && (ra == OFF_CNT_HI);
	wire rd_cnt_lo  = ar_take && (ra == OFF_CNT_LO);
	wire rd_alt_hi  = ar_take && (ra == OFF_ALT_HI);
	wire rd_alt_lo  = ar_take && (ra == OFF_ALT_LO);
	wire rd_status  = ar_take && (ra == OFF_STATUS);
	wire wr_cnt_lo  = wr_go && (wa == OFF_CNT_LO);
	wire wr_alt_lo  = wr_go && (wa == OFF_ALT_LO);
	wire wr_ctrl1   = wr_go && (wa == OFF_CTRL1);
	wire wr_ctrl2   = wr_go && (wa == OFF_CTRL2);
	wire [1:0] rd_cap_hi = {ar_take && (ra == OFF_CAP2_HI),
		ar_take && (ra == OFF_CAP1_HI)};
	wire [1:0] rd_cap_lo = {ar_take && (ra == OFF_CAP2_LO),
		ar_take && (ra == OFF_CAP1_LO)};
	wire [1:0] wr_cap_lo = {wr_go && (wa == OFF_CAP2_LO),
		wr_go && (wa == OFF_CAP1_LO)};
	wire [1:0] rd_cmp_lo = {ar_take && (ra == OFF_CMP2_LO),
		ar_take && (ra == OFF_CMP1_LO)};
	wire [1:0] wr_cmp_hi = {wr_go && (wa == OFF_CMP2_HI),
		wr_go && (wa == OFF_CMP1_HI)};
	wire [1:0] wr_cmp_lo = {wr_go && (wa == OFF_CMP2_LO),
		wr_go && (wa == OFF_CMP1_LO)};

	// Either low byte shows the latched byte while a high read is pending.
	wire [7:0] lo_view = lo_pend_r ? lo_latch_r : cnt_r[7:0];
	wire [7:0] rd_byte =
		(ra == OFF_CNT_HI || ra == OFF_ALT_HI) ? cnt_r[15:8] :
		(ra == OFF_CNT_LO || ra == OFF_ALT_LO) ? lo_view :
		(ra == OFF_CAP1_HI) ? cap_val_r[0][15:8] :
		(ra == OFF_CAP1_LO) ? cap_val_r[0][7:0] :
		(ra == OFF_CAP2_HI) ? cap_val_r[1][15:8] :
		(ra == OFF_CAP2_LO) ? cap_val_r[1][7:0] :
		(ra == OFF_CMP1_HI) ? cmp_val_r[0][15:8] :
		(ra == OFF_CMP1_LO) ? cmp_val_r[0][7:0] :
		(ra == OFF_CMP2_HI) ? cmp_val_r[1][15:8] :
		(ra == OFF_CMP2_LO) ? cmp_val_r[1][7:0] :
		(ra == OFF_STATUS)  ? {3'h0, flags_r} :
		(ra == OFF_CTRL1)   ? ctrl1_r :
		(ra == OFF_CTRL2)   ? ctrl2_r : 8'h00;

	// Timer tick: prescaler taps or a synchronised external edge.
	wire [1:0] cks      = ctrl2_r.clock_select;
	wire       div_tick = (cks == CKS_DIV2) ? pre_r[0] :
		(cks == CKS_DIV4) ? (&pre_r[1:0]) : (&pre_r);
	wire       ext_edge = ctrl2_r.external_edge_select ?
		(ext_s2_r & ~ext_s3_r) : (~ext_s2_r & ext_s3_r);
	wire       tick     = ~halt_req &
		((cks == CKS_EXT) ? ext_edge : div_tick);
	wire       reload   = wr_cnt_lo | wr_alt_lo;
	wire       ovf_evt  = tick & ~reload & (cnt_r == CNT_WRAP);

	// Capture edges, channel one is taken over by the pulse modes.
	wire [1:0] cap_sel  = {ctrl2_r.capture_edge_two, ctrl1_r.capture_edge_one};
	wire [1:0] cap_edge = (cap_sel & cap_s2_r & ~cap_s3_r) |
		(~cap_sel & ~cap_s2_r & cap_s3_r);
	wire       pulse_md = ctrl2_r.single_pulse_mode | ctrl2_r.pwm_mode;
	wire [1:0] cap_evt  = cap_edge & ~cap_block_r &
		{1'b1, ~pulse_md};

	// Compare matches on each tick against the same count as capture.
	wire [1:0] cmp_evt = {tick & ~cmp_hold_r[1] & (cnt_r == cmp_val_r[1]),
		tick & ~cmp_hold_r[0] & (cnt_r == cmp_val_r[0])};
	wire [1:0] pin_en  = {ctrl2_r.pin_enable_two, ctrl2_r.pin_enable_one};
	wire [1:0] pin_lvl = {ctrl1_r.out_level_two, ctrl1_r.out_level_one};

	// Flag clearing is a two step sequence; a new event beats the clear.
	wire [4:0] acc_lo  = {rd_cmp_lo[1] | wr_cmp_lo[1],
		rd_cmp_lo[0] | wr_cmp_lo[0], rd_cap_lo[1] | wr_cap_lo[1],
		rd_cap_lo[0] | wr_cap_lo[0], rd_cnt_lo | wr_cnt_lo};
	wire [4:0] clr     = arm_r & acc_lo;
	wire [4:0] set     = {cmp_evt, cap_evt, ovf_evt};
	wire [4:0] flags_n = (flags_r & ~clr) | set;
	wire [4:0] arm_n   = (arm_r & ~clr) | (rd_status ? flags_r : 5'h00);
	wire       irq_n   = ~cpu_irq_mask & (
		(flags_r[ST_OVF] & ctrl1_r.overflow_irq_enable) |
		((flags_r[ST_CAP1] | flags_r[ST_CAP2]) &
			ctrl1_r.capture_irq_enable) |
		((flags_r[ST_CMP1] | flags_r[ST_CMP2]) &
			ctrl1_r.compare_irq_enable));

	// Bus slave registers; ready falls as soon as a channel is holding.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 8'h00;
			w_lane_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= RESP_OKAY;
			rdata_r       <= 32'h0000_0000;
		end else begin
			aw_full_r     <= aw_full_n;
			w_full_r      <= w_full_n;
			s_axi_awready <= ~aw_full_n & ~bvalid_n;
			s_axi_wready  <= ~w_full_n & ~bvalid_n;
			s_axi_bvalid  <= bvalid_n;
			s_axi_arready <= ~rvalid_n;
			s_axi_rvalid  <= rvalid_n;
			if (aw_take) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (ar_take) begin
				rdata_r     <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
	assign s_axi_rdata = rdata_r;

	// Pins from outside pass two flip-flops; the third only feeds edges.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			cap_s1_r <= 2'h0;
			cap_s2_r <= 2'h0;
			cap_s3_r <= 2'h0;
		end else begin
			ext_s1_r <= external_clock_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			cap_s1_r <= capture_pin;
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
		end
	end

	// Counter, prescaler and read latch. Halt keeps the count in place.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r      <= CNT_RELOAD;
			pre_r      <= 3'h0;
			lo_latch_r <= 8'h00;
			lo_pend_r  <= 1'b0;
		end else begin
			pre_r <= pre_r + 3'h1;
			if (reload) begin
				cnt_r <= CNT_RELOAD;
			end else if (tick) begin
				cnt_r <= cnt_r + 16'h0001;
			end
			if ((rd_cnt_hi | rd_alt_hi) & ~lo_pend_r) begin
				lo_latch_r <= cnt_r[7:0];
				lo_pend_r  <= 1'b1;
			end else if (rd_cnt_lo | rd_alt_lo) begin
				lo_pend_r  <= 1'b0;
			end
		end
	end

	// Flags, control and interrupt.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_r   <= FLAG_RESET;
			arm_r     <= FLAG_RESET;
			ctrl1_r   <= CTRL_RESET;
			ctrl2_r   <= CTRL_RESET;
			timer_irq <= 1'b0;
		end else begin
			flags_r   <= flags_n;
			arm_r     <= arm_n;
			timer_irq <= irq_n;
			if (wr_ctrl1) begin
				ctrl1_r <= w_data_r;
			end
			if (wr_ctrl2) begin
				ctrl2_r <= w_data_r;
			end
		end
	end

	// Per channel capture and compare state.
	for (genvar i = 0; i < 2; i++) begin : g_chan
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				cap_val_r[i]          <= 16'h0000;
				cap_block_r[i]        <= 1'b0;
				cmp_val_r[i]          <= CMP_RESET;
				cmp_hold_r[i]         <= 1'b0;
				compare_output_pin[i] <= 1'b0;
			end else begin
				if (cap_evt[i]) begin
					cap_val_r[i] <= cnt_r;
				end
				if (rd_cap_hi[i]) begin
					cap_block_r[i] <= 1'b1;
				end else if (rd_cap_lo[i]) begin
					cap_block_r[i] <= 1'b0;
				end
				if (wr_cmp_hi[i]) begin
					cmp_val_r[i][15:8] <= w_data_r;
					cmp_hold_r[i]      <= 1'b1;
				end else if (wr_cmp_lo[i]) begin
					cmp_val_r[i][7:0]  <= w_data_r;
					cmp_hold_r[i]      <= 1'b0;
				end
				if (cmp_evt[i] & pin_en[i]) begin
					compare_output_pin[i] <= pin_lvl[i];
				end
			end
		end
	end

	// Checks on the timer core.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	property p_reload;
		reload |=> (cnt_r == CNT_RELOAD);
	endproperty
	a_reload: assert property (p_reload) else $error("reload missed");

	property p_step;
		(tick && !reload) |=> (cnt_r == 16'($past(cnt_r) + 16'h0001));
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");

	property p_ovf_set;
		ovf_evt |=> flags_r[ST_OVF] ##1
			(flags_r[ST_OVF] || $past(clr[ST_OVF]));
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow lost");

	property p_alt_keeps;
		(rd_alt_lo && flags_r[ST_OVF] && !rd_cnt_lo && !wr_cnt_lo)
			|=> flags_r[ST_OVF];
	endproperty
	a_alt_keeps: assert property (p_alt_keeps) else $error("alt cleared");

	property p_irq_mask;
		cpu_irq_mask |=> !timer_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq masked");

	property p_latch_frozen;
		(lo_pend_r && (rd_cnt_hi || rd_alt_hi)) |=>
			(lo_latch_r == $past(lo_latch_r)) && lo_pend_r;
	endproperty
	a_latch_frozen: assert property (p_latch_frozen) else $error("latch");

	property p_cap_value;
		cap_evt[1] |=> (cap_val_r[1] == $past(cnt_r)) && flags_r[ST_CAP2];
	endproperty
	a_cap_value: assert property (p_cap_value) else $error("capture");

	property p_cap_block;
		(cap_block_r[0] && !rd_cap_lo[0]) |=> $stable(cap_val_r[0]);
	endproperty
	a_cap_block: assert property (p_cap_block) else $error("blocked cap");

	property p_cmp_hold;
		$rose(flags_r[ST_CMP1]) |-> !$past(cmp_hold_r[0]);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("held match");

	property p_halt;
		(halt_req && !reload) |=> $stable(cnt_r);
	endproperty
	a_halt: assert property (p_halt) else $error("halt counted");

	property p_div2;
		(cks == CKS_DIV2 && div_tick) |=> !div_tick;
	endproperty
	a_div2: assert property (p_div2) else $error("prescale");

	c_overflow: cover property (ovf_evt);
	c_capture: cover property (cap_evt[0] ##[1:50] rd_cap_lo[0]);
	c_compare: cover property (cmp_evt[0] && pin_en[0]);
	c_read_seq: cover property (rd_cnt_hi ##[1:20] rd_cnt_lo);

endmodule : frtcc_timer

// *** frtcc_pkg.sv ***
package frtcc_pkg;

	// Register byte addresses on the bus, one aligned word per byte register.
	localparam logic [7:0] OFF_CNT_HI  = 8'h00;
	localparam logic [7:0] OFF_CNT_LO  = 8'h04;
	localparam logic [7:0] OFF_ALT_HI  = 8'h08;
	localparam logic [7:0] OFF_ALT_LO  = 8'h0C;
	localparam logic [7:0] OFF_CAP1_HI = 8'h10;
	localparam logic [7:0] OFF_CAP1_LO = 8'h14;
	localparam logic [7:0] OFF_CAP2_HI = 8'h18;
	localparam logic [7:0] OFF_CAP2_LO = 8'h1C;
	localparam logic [7:0] OFF_CMP1_HI = 8'h20;
	localparam logic [7:0] OFF_CMP1_LO = 8'h24;
	localparam logic [7:0] OFF_CMP2_HI = 8'h28;
	localparam logic [7:0] OFF_CMP2_LO = 8'h2C;
	localparam logic [7:0] OFF_STATUS  = 8'h30;
	localparam logic [7:0] OFF_CTRL1   = 8'h34;
	localparam logic [7:0] OFF_CTRL2   = 8'h38;

	// Counter and compare values after reset, and the wrap point.
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CNT_WRAP   = 16'hFFFF;
	localparam logic [15:0] CMP_RESET  = 16'h8000;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [4:0]  FLAG_RESET = 5'h00;

	// Clock select encodings.
	localparam logic [1:0] CKS_DIV2 = 2'h0;
	localparam logic [1:0] CKS_DIV4 = 2'h1;
	localparam logic [1:0] CKS_DIV8 = 2'h2;
	localparam logic [1:0] CKS_EXT  = 2'h3;

	// Status bit positions.
	localparam int ST_OVF  = 0;
	localparam int ST_CAP1 = 1;
	localparam int ST_CAP2 = 2;
	localparam int ST_CMP1 = 3;
	localparam int ST_CMP2 = 4;

	// Bus responses and the least gap of the external clock in CPU edges.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         EXT_MIN_GAP = 4;

	typedef struct packed {
		logic [1:0] spare;
		logic       out_level_two;
		logic       out_level_one;
		logic       capture_edge_one;
		logic       overflow_irq_enable;
		logic       compare_irq_enable;
		logic       capture_irq_enable;
	} frtcc_ctrl1_s;

	typedef struct packed {
		logic       pwm_mode;
		logic       single_pulse_mode;
		logic       pin_enable_two;
		logic       pin_enable_one;
		logic       capture_edge_two;
		logic       external_edge_select;
		logic [1:0] clock_select;
	} frtcc_ctrl2_s;

endpackage : frtcc_pkg

// *** frtcc_pin_model.sv ***
`timescale 1ns/1ps
// Stands in for the signal sources wired to the timer pins.
module frtcc_pin_model (
	input  wire logic ref_clk,
	output logic [1:0] capture_pin,
	output logic       external_clock_pin
);
	// Pins idle low until a test moves them.
	initial begin
		capture_pin = 2'h0;
		external_clock_pin = 1'b0;
	end

	// Each level is held six clocks. That keeps active edges four or more
	// CPU edges apart, and the synchroniser and flag logic settle meanwhile.
	task automatic set_ext(input logic v);
		@(posedge ref_clk);
		external_clock_pin <= v;
		repeat (6) @(posedge ref_clk);
	endtask : set_ext

	// A capture pin moves the same way, one channel at a time.
	task automatic set_cap(input int ch, input logic v);
		@(posedge ref_clk);
		capture_pin[ch] <= v;
		repeat (6) @(posedge ref_clk);
	endtask : set_cap
endmodule : frtcc_pin_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import frtcc_pkg::*;
	logic        ref_clk, arst_n, halt_req, cpu_irq_mask, timer_irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, cap_pin, cmp_pin;
	logic        ext_pin;
	int          num_errors, comparisons;

	// Device under test and the pin sources.
	frtcc_timer uut (.ref_clk, .arst_n, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cpu_irq_mask, .halt_req,
		.capture_pin(cap_pin), .external_clock_pin(ext_pin),
		.compare_output_pin(cmp_pin), .timer_irq);
	frtcc_pin_model pins (.ref_clk, .capture_pin(cap_pin),
		.external_clock_pin(ext_pin));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Reset, halt and interrupt mask move together, just after an edge.
	task automatic drive_in(input logic rn, input logic h, input logic m);
		arst_n <= rn;
		halt_req <= h;
		cpu_irq_mask <= m;
	endtask : drive_in

	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// The read waits for rvalid; the watchdog ends a hang.
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic wrk(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, 4'hF, r);
		chk({6'h00, r}, {6'h00, RESP_OKAY});
	endtask : wrk

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
		chk({6'h00, r}, {6'h00, RESP_OKAY});
	endtask : rdc

	// Counting is opened for exactly n clocks, then frozen again.
	task automatic run(input int n);
		@(posedge ref_clk);
		drive_in(arst_n, 1'b0, cpu_irq_mask);
		repeat (n) @(posedge ref_clk);
		drive_in(arst_n, 1'b1, cpu_irq_mask);
		repeat (2) @(posedge ref_clk);
	endtask : run

	task automatic t_bus;
		logic [7:0] d;
		logic [1:0] r;
		rd(8'h3C, d, r);
		chk({6'h00, r}, {6'h00, RESP_SLVERR});
		chk(d, 8'h00);
		wr(8'h40, 8'h00, 4'hF, r);
		chk({6'h00, r}, {6'h00, RESP_SLVERR});
		wr(8'h31, 8'h00, 4'hF, r);
		chk({6'h00, r}, {6'h00, RESP_SLVERR});
		wrk(OFF_STATUS, 8'hFF);
		rdc(OFF_STATUS, 8'h00);
		rdc(OFF_CMP1_HI, 8'h80);
		rdc(OFF_CMP2_LO, 8'h00);
		// A write whose low lane is off is answered but changes nothing.
		wr(OFF_CMP2_HI, 8'h12, 4'hE, r);
		chk({6'h00, r}, {6'h00, RESP_OKAY});
		rdc(OFF_CMP2_HI, 8'h80);
		rdc(OFF_CTRL2, 8'h00);
	endtask : t_bus

	task automatic t_latch;
		rdc(OFF_CNT_HI, 8'hFF);
		run(10);
		rdc(OFF_ALT_HI, 8'h00);
		rdc(OFF_CNT_LO, 8'hFC);
		rdc(OFF_ALT_LO, 8'h01);
	endtask : t_latch

	task automatic t_ovf;
		rdc(OFF_STATUS, 8'h01);
		wrk(OFF_ALT_LO, 8'h00);
		rdc(OFF_STATUS, 8'h01);
		wrk(OFF_CNT_LO, 8'h00);
		rdc(OFF_STATUS, 8'h00);
		rdc(OFF_CNT_HI, 8'hFF);
		rdc(OFF_CNT_LO, 8'hFC);
		wrk(OFF_CTRL1, 8'h04);
		run(16);
		rdc(OFF_ALT_LO, 8'h04);
		chk({7'h00, timer_irq}, 8'h00);
		@(posedge ref_clk);
		drive_in(arst_n, halt_req, 1'b0);
		repeat (3) @(posedge ref_clk);
		chk({7'h00, timer_irq}, 8'h01);
		rdc(OFF_STATUS, 8'h01);
		rdc(OFF_ALT_LO, 8'h04);
		rdc(OFF_STATUS, 8'h01);
		rdc(OFF_CNT_LO, 8'h04);
		repeat (3) @(posedge ref_clk);
		chk({7'h00, timer_irq}, 8'h00);
		rdc(OFF_STATUS, 8'h00);
		wrk(OFF_CTRL1, 8'h00);
	endtask : t_ovf

	// A window of 64 clocks holds a whole number of prescaler periods.
	task automatic t_div;
		logic [7:0] c0;
		logic [7:0] c1;
		logic [1:0] r;
		for (int k = 0; k < 3; k++) begin
			wrk(OFF_CTRL2, 8'(k));
			rd(OFF_ALT_LO, c0, r);
			run(64);
			rd(OFF_ALT_LO, c1, r);
			chk(c1 - c0, 8'h40 >> (k + 1));
		end
	endtask : t_div

	task automatic t_ext;
		wrk(OFF_CTRL2, 8'h07);
		@(posedge ref_clk);
		drive_in(arst_n, 1'b0, cpu_irq_mask);
		wrk(OFF_CNT_LO, 8'h00);
		pins.set_ext(1'b1);
		rdc(OFF_ALT_LO, 8'hFD);
		pins.set_ext(1'b0);
		rdc(OFF_ALT_LO, 8'hFD);
		wrk(OFF_CTRL2, 8'h03);
		pins.set_ext(1'b1);
		rdc(OFF_ALT_LO, 8'hFD);
		pins.set_ext(1'b0);
		rdc(OFF_ALT_LO, 8'hFE);
	endtask : t_ext

	task automatic t_cap;
		wrk(OFF_CTRL2, 8'h07);
		wrk(OFF_CTRL1, 8'h09);
		wrk(OFF_CNT_LO, 8'h00);
		pins.set_cap(0, 1'b1);
		rdc(OFF_STATUS, 8'h02);
		chk({7'h00, timer_irq}, 8'h01);
		rdc(OFF_CAP1_HI, 8'hFF);
		pins.set_ext(1'b1);
		pins.set_cap(0, 1'b0);
		pins.set_cap(0, 1'b1);
		rdc(OFF_CAP1_LO, 8'hFC);
		rdc(OFF_STATUS, 8'h00);
		chk({7'h00, timer_irq}, 8'h00);
		pins.set_cap(0, 1'b0);
		pins.set_cap(0, 1'b1);
		rdc(OFF_STATUS, 8'h02);
		rdc(OFF_CAP1_HI, 8'hFF);
		rdc(OFF_CAP1_LO, 8'hFD);
		wrk(OFF_CTRL2, 8'h4F);
		pins.set_cap(0, 1'b0);
		pins.set_cap(0, 1'b1);
		pins.set_cap(1, 1'b1);
		// A low read before any status read must leave the flag alone.
		rdc(OFF_CAP2_LO, 8'hFD);
		rdc(OFF_STATUS, 8'h04);
		rdc(OFF_STATUS, 8'h04);
		rdc(OFF_CAP2_LO, 8'hFD);
		rdc(OFF_STATUS, 8'h00);
		wrk(OFF_CTRL1, 8'h00);
	endtask : t_cap

	// The second compare is left suspended after a lone high write.
	task automatic t_cmp;
		wrk(OFF_CTRL2, 8'h07);
		wrk(OFF_CMP1_HI, 8'hFF);
		wrk(OFF_CMP1_LO, 8'hFE);
		wrk(OFF_CMP2_HI, 8'hFF);
		wrk(OFF_CMP2_LO, 8'hFE);
		wrk(OFF_CMP2_HI, 8'hFF);
		wrk(OFF_CTRL1, 8'h10);
		wrk(OFF_CTRL2, 8'h17);
		pins.set_ext(1'b0);
		pins.set_ext(1'b1);
		rdc(OFF_STATUS, 8'h00);
		pins.set_ext(1'b0);
		pins.set_ext(1'b1);
		rdc(OFF_STATUS, 8'h08);
		chk({6'h00, cmp_pin}, 8'h01);
		wrk(OFF_CMP1_LO, 8'hFE);
		rdc(OFF_STATUS, 8'h00);
		rdc(OFF_CMP1_HI, 8'hFF);
		rdc(OFF_CMP1_LO, 8'hFE);
	endtask : t_cmp

	// A reset in mid-run puts counter, compares, flags and pins back.
	task automatic t_rst;
		pins.set_ext(1'b0);
		pins.set_ext(1'b1);
		rdc(OFF_STATUS, 8'h01);
		@(posedge ref_clk);
		drive_in(1'b0, 1'b1, 1'b1);
		repeat (2) @(posedge ref_clk);
		drive_in(1'b1, 1'b1, 1'b1);
		repeat (2) @(posedge ref_clk);
		chk({6'h00, cmp_pin}, 8'h00);
		rdc(OFF_CNT_HI, 8'hFF);
		rdc(OFF_CNT_LO, 8'hFC);
		rdc(OFF_CMP1_LO, 8'h00);
		rdc(OFF_STATUS, 8'h00);
	endtask : t_rst

	task automatic test_done;
		if (num_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Reset with the counter frozen so that its values can be foreseen.
	initial begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready, arst_n} = '0;
		wstrb = 4'hF;
		halt_req = 1'b1;
		cpu_irq_mask = 1'b1;
		repeat (8) @(posedge ref_clk);
		drive_in(1'b1, halt_req, cpu_irq_mask);
		repeat (2) @(posedge ref_clk);
		t_bus();
		t_latch();
		t_ovf();
		t_div();
		t_ext();
		t_cap();
		t_cmp();
		t_rst();
		test_done();
	end

	// The tests need under a thousand clocks; this bound cuts a hang.
	initial begin
		repeat (30000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end
endmodule : tb_top
